// *** hw/amd_pkg.sv ***
package amd_pkg;

  // ----------------------------------------------------------------
  // Prefix bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] SECOND_INDEX_PREFIX = 8'h90;
  localparam logic [7:0] SECOND_INDEX_INDIRECT_PREFIX = 8'h91;
  localparam logic [7:0] INDIRECT_PREFIX = 8'h92;

  // ----------------------------------------------------------------
  // Base addressing modes selected by the opcode
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AMD_INHERENT,
    AMD_IMMEDIATE,
    AMD_DIRECT_SHORT,
    AMD_DIRECT_LONG,
    AMD_INDEXED_NONE,
    AMD_INDEXED_SHORT,
    AMD_INDEXED_LONG,
    AMD_RELATIVE
  } amd_mode_t;

  // Resolved mode after the prefix is applied.
  typedef enum logic [3:0] {
    AMD_R_INHERENT,
    AMD_R_IMMEDIATE,
    AMD_R_DIR_SHORT,
    AMD_R_DIR_LONG,
    AMD_R_IDX_NONE,
    AMD_R_IDX_SHORT,
    AMD_R_IDX_LONG,
    AMD_R_IND_SHORT,
    AMD_R_IND_LONG,
    AMD_R_INDIDX_SHORT,
    AMD_R_INDIDX_LONG,
    AMD_R_REL_DIRECT,
    AMD_R_REL_INDIRECT
  } amd_rmode_t;

  // Byte offered by the instruction stream.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } amd_byte_t;

  // Decoded result.
  typedef struct packed {
    amd_rmode_t mode;
    logic use_y;
    logic [15:0] ea;
    logic [7:0] operand;
    logic [15:0] pc;
    logic [2:0] length;
  } amd_result_t;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] ZERO_PAGE_MASK = 16'h00FF;
  localparam logic [2:0] MAX_LENGTH = 3'h4;

endpackage

// *** hw/amd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Inherent instruction is one opcode byte.
// - Immediate: opcode then operand value byte.
// - Short direct: one address byte, page zero.
// - Long direct: two address bytes, full space.
// - Indexed address is unsigned index plus offset.
// - Indexed no offset uses index register alone.
// - Short indexed: byte offset, up to 1FE.
// - Long indexed: word offset, full space.
// - Short indirect: byte pointer from page zero.
// - Long indirect forms fetch word pointer.
// - Indirect indexed adds index to pointer.
// - Short indirect indexed reaches up to 1FE.
// - Relative adds signed 8-bit offset to PC.
// - Offset added to next instruction address.
// - Relative offset inline or read from memory.
// - Prefix 90 switches to second index register.
// - Prefix 92 selects indirect forms.
// - Prefix 91 switches indirect indexed to second.
// - Optional prefix, opcode, zero to two bytes.
// - Memory-to-memory opcodes only use short forms.
module amd_decoder (
  input wire logic clk,
  input wire logic srst,
  input wire amd_pkg::amd_byte_t ibyte,
  output logic ibyte_ready,
  input wire amd_pkg::amd_mode_t op_mode,
  input wire logic op_mem_to_mem,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire amd_pkg::amd_byte_t mem_rdata,
  output logic done,
  output amd_pkg::amd_result_t result,
  output logic busy
);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum {
    S_OPCODE,
    S_EXT1,
    S_EXT2,
    S_PTR_HI,
    S_PTR_LO,
    S_DONE
  } amd_state_t;

  amd_state_t state;
  logic [7:0] prefix;
  logic have_prefix;
  amd_pkg::amd_rmode_t rmode;
  logic use_y;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [15:0] pc;
  logic [2:0] len;
  logic [7:0] ptr_hi;

  // Resolved mode of the opcode now on the stream.
  amd_pkg::amd_rmode_t next_rmode;
  logic next_use_y;
  logic is_prefix;

  assign is_prefix = (ibyte.data == amd_pkg::SECOND_INDEX_PREFIX) ||
                     (ibyte.data == amd_pkg::SECOND_INDEX_INDIRECT_PREFIX) ||
                     (ibyte.data == amd_pkg::INDIRECT_PREFIX);

  always_comb begin
    next_use_y = 1'b0;
    next_rmode = amd_pkg::AMD_R_INHERENT;
    unique case (op_mode)
      amd_pkg::AMD_INHERENT: next_rmode = amd_pkg::AMD_R_INHERENT;
      amd_pkg::AMD_IMMEDIATE: next_rmode = amd_pkg::AMD_R_IMMEDIATE;
      amd_pkg::AMD_DIRECT_SHORT: next_rmode = amd_pkg::AMD_R_DIR_SHORT;
      amd_pkg::AMD_DIRECT_LONG: next_rmode = op_mem_to_mem ? amd_pkg::AMD_R_DIR_SHORT : amd_pkg::AMD_R_DIR_LONG;
      amd_pkg::AMD_INDEXED_NONE: next_rmode = amd_pkg::AMD_R_IDX_NONE;
      amd_pkg::AMD_INDEXED_SHORT: next_rmode = amd_pkg::AMD_R_IDX_SHORT;
      amd_pkg::AMD_INDEXED_LONG: next_rmode = op_mem_to_mem ? amd_pkg::AMD_R_IDX_SHORT : amd_pkg::AMD_R_IDX_LONG;
      amd_pkg::AMD_RELATIVE: next_rmode = amd_pkg::AMD_R_REL_DIRECT;
      default: next_rmode = amd_pkg::AMD_R_INHERENT;
    endcase
    if (have_prefix) begin
      if (prefix == amd_pkg::SECOND_INDEX_PREFIX) begin
        next_use_y = (next_rmode != amd_pkg::AMD_R_REL_DIRECT);
      end
      if (prefix == amd_pkg::INDIRECT_PREFIX || prefix == amd_pkg::SECOND_INDEX_INDIRECT_PREFIX) begin
        unique case (next_rmode)
          amd_pkg::AMD_R_DIR_SHORT: next_rmode = amd_pkg::AMD_R_IND_SHORT;
          amd_pkg::AMD_R_DIR_LONG: next_rmode = amd_pkg::AMD_R_IND_LONG;
          amd_pkg::AMD_R_IDX_SHORT: next_rmode = amd_pkg::AMD_R_INDIDX_SHORT;
          amd_pkg::AMD_R_IDX_LONG: next_rmode = amd_pkg::AMD_R_INDIDX_LONG;
          amd_pkg::AMD_R_REL_DIRECT: next_rmode = amd_pkg::AMD_R_REL_INDIRECT;
          default: next_rmode = next_rmode;
        endcase
      end
      if (prefix == amd_pkg::SECOND_INDEX_INDIRECT_PREFIX) begin
        next_use_y = (next_rmode == amd_pkg::AMD_R_INDIDX_SHORT) ||
                     (next_rmode == amd_pkg::AMD_R_INDIDX_LONG);
      end
    end
  end

  // Number of inline bytes after the opcode per resolved mode.
  function automatic logic [1:0] amd_ext_bytes(input amd_pkg::amd_rmode_t m);
    unique case (m)
      amd_pkg::AMD_R_INHERENT, amd_pkg::AMD_R_IDX_NONE: amd_ext_bytes = 2'h0;
      amd_pkg::AMD_R_DIR_LONG, amd_pkg::AMD_R_IDX_LONG: amd_ext_bytes = 2'h2;
      default: amd_ext_bytes = 2'h1;
    endcase
  endfunction

  function automatic logic amd_ptr_word(input amd_pkg::amd_rmode_t m);
    amd_ptr_word = (m == amd_pkg::AMD_R_IND_LONG) || (m == amd_pkg::AMD_R_INDIDX_LONG);
  endfunction

  function automatic logic amd_needs_ptr(input amd_pkg::amd_rmode_t m);
    amd_needs_ptr = (m == amd_pkg::AMD_R_IND_SHORT) || (m == amd_pkg::AMD_R_IND_LONG) ||
                    (m == amd_pkg::AMD_R_INDIDX_SHORT) || (m == amd_pkg::AMD_R_INDIDX_LONG) ||
                    (m == amd_pkg::AMD_R_REL_INDIRECT);
  endfunction

  assign ibyte_ready = (state == S_OPCODE) || (state == S_EXT1) || (state == S_EXT2);
  // Busy covers a held prefix too, so the core never mistakes it for an idle gap.
  assign busy = (state != S_OPCODE) || have_prefix;

  logic take;
  assign take = ibyte.valid && ibyte_ready;

  // ----------------------------------------------------------------
  // Instruction byte sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= S_OPCODE;
      prefix <= 8'h00;
      have_prefix <= 1'b0;
      rmode <= amd_pkg::AMD_R_INHERENT;
      use_y <= 1'b0;
      b1 <= 8'h00;
      b2 <= 8'h00;
      len <= 3'h0;
      ptr_hi <= 8'h00;
    end else begin
      unique case (state)
        S_OPCODE: begin
          // A prefix value seen while one is held is taken as the opcode.
          // This way a run of prefix bytes can never stall the stream.
          if (take && is_prefix && !have_prefix) begin
            prefix <= ibyte.data;
            have_prefix <= 1'b1;
            len <= 3'h1;
          end else if (take) begin
            // prefix consumed by this opcode only
            have_prefix <= 1'b0;
            rmode <= next_rmode;
            use_y <= next_use_y;
            len <= have_prefix ? 3'h2 : 3'h1;
            if (amd_ext_bytes(next_rmode) == 2'h0) begin
              state <= S_DONE;
            end else begin
              state <= S_EXT1;
            end
          end
        end
        S_EXT1: begin
          if (take) begin
            b1 <= ibyte.data;
            len <= len + 3'h1;
            if (amd_ext_bytes(rmode) == 2'h2) begin
              state <= S_EXT2;
            end else if (amd_needs_ptr(rmode)) begin
              state <= amd_ptr_word(rmode) ? S_PTR_HI : S_PTR_LO;
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_EXT2: begin
          if (take) begin
            b2 <= ibyte.data;
            len <= len + 3'h1;
            state <= S_DONE;
          end
        end
        S_PTR_HI: begin
          // high byte of word pointer first
          if (mem_rdata.valid) begin
            ptr_hi <= mem_rdata.data;
            state <= S_PTR_LO;
          end
        end
        S_PTR_LO: begin
          if (mem_rdata.valid) begin
            b2 <= mem_rdata.data;
            if (!amd_ptr_word(rmode)) begin
              ptr_hi <= 8'h00;
            end
            state <= S_DONE;
          end
        end
        S_DONE: begin
          state <= S_OPCODE;
        end
        default: state <= S_OPCODE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pointer fetch addresses
  // ----------------------------------------------------------------
  // Pointer addresses live in page zero; word pointers wrap there.
  assign mem_req = ((state == S_PTR_HI) || (state == S_PTR_LO));
  always_comb begin
    mem_addr = {8'h00, b1};
    if (state == S_PTR_LO && amd_ptr_word(rmode)) begin
      mem_addr = {8'h00, b1 + 8'h01};
    end
  end

  // ----------------------------------------------------------------
  // Effective address and program counter
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic [15:0] next_ea;
  logic [15:0] next_pc;
  logic [7:0] rel_off;
  assign idx = use_y ? idx_y : idx_x;
  // The program counter keeps no carry, so lengths and jumps wrap at the top of the space.
  assign next_pc = pc + {13'h0000, len};

  always_comb begin
    next_ea = 16'h0000;
    rel_off = b1;
    unique case (rmode)
      amd_pkg::AMD_R_DIR_SHORT: next_ea = {8'h00, b1};
      amd_pkg::AMD_R_DIR_LONG: next_ea = {b1, b2};
      amd_pkg::AMD_R_IDX_NONE: next_ea = {8'h00, idx};
      amd_pkg::AMD_R_IDX_SHORT: next_ea = {8'h00, idx} + {8'h00, b1};
      amd_pkg::AMD_R_IDX_LONG: next_ea = {b1, b2} + {8'h00, idx};
      amd_pkg::AMD_R_IND_SHORT: next_ea = {8'h00, b2};
      amd_pkg::AMD_R_IND_LONG: next_ea = {ptr_hi, b2};
      amd_pkg::AMD_R_INDIDX_SHORT: next_ea = {8'h00, b2} + {8'h00, idx};
      amd_pkg::AMD_R_INDIDX_LONG: next_ea = {ptr_hi, b2} + {8'h00, idx};
      amd_pkg::AMD_R_REL_INDIRECT: rel_off = b2;
      default: next_ea = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc <= amd_pkg::PC_RESET;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= (state == S_DONE);
      if (state == S_DONE) begin
        result.mode <= rmode;
        result.use_y <= use_y;
        result.ea <= next_ea;
        result.operand <= (rmode == amd_pkg::AMD_R_IMMEDIATE) ? b1 : 8'h00;
        result.length <= len;
        if (rmode == amd_pkg::AMD_R_REL_DIRECT || rmode == amd_pkg::AMD_R_REL_INDIRECT) begin
          pc <= next_pc + {{8{rel_off[7]}}, rel_off};
          result.pc <= next_pc + {{8{rel_off[7]}}, rel_off};
        end else begin
          pc <= next_pc;
          result.pc <= next_pc;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking amd_cb @(posedge clk); endclocking
  default disable iff (srst);

  a_inherent_len: assert property (done && result.mode == amd_pkg::AMD_R_INHERENT |-> result.length <= 3'h2)
    else $error("inherent length wrong");
  a_short_direct_page: assert property (done && result.mode == amd_pkg::AMD_R_DIR_SHORT |->
    result.ea[15:8] == 8'h00)
    else $error("short direct left page zero");
  a_short_idx_range: assert property (done && result.mode == amd_pkg::AMD_R_IDX_SHORT |-> result.ea <= 16'h01FE)
    else $error("short indexed out of range");
  a_indidx_range: assert property (done && result.mode == amd_pkg::AMD_R_INDIDX_SHORT |->
    result.ea <= 16'h01FE)
    else $error("short indirect indexed out of range");
  a_idx_none_page: assert property (done && result.mode == amd_pkg::AMD_R_IDX_NONE |->
    result.ea == {8'h00, (result.use_y ? $past(idx_y) : $past(idx_x))})
    else $error("no-offset index address wrong");
  a_prefix_single: assert property (state == S_OPCODE && take && !is_prefix |=> !have_prefix)
    else $error("prefix outlived its opcode");
  a_ptr_fetch: assert property (state == S_EXT1 && take && amd_ptr_word(rmode) |=>
    mem_req && mem_addr == {8'h00, $past(ibyte.data)})
    else $error("word pointer fetch missing");
  a_pc_advance: assert property (state == S_DONE && rmode == amd_pkg::AMD_R_INHERENT |=>
    pc == $past(pc) + {13'h0000, $past(len)})
    else $error("pc did not advance by length");
  a_max_length: assert property (done |-> result.length <= amd_pkg::MAX_LENGTH)
    else $error("instruction too long");

  // The first two checks below tie the handed-over result to the bytes that made it.
  a_imm_operand: assert property (state == S_DONE && rmode == amd_pkg::AMD_R_IMMEDIATE |=>
    result.operand == $past(b1))
    else $error("immediate operand not passed on");
  a_rel_target: assert property (state == S_DONE && rmode == amd_pkg::AMD_R_REL_DIRECT |=>
    result.pc == $past(pc) + {13'h0000, $past(len)} + {{8{$past(b1[7])}}, $past(b1)})
    else $error("relative target wrong");
  a_relative_no_y: assert property (done &&
    (result.mode == amd_pkg::AMD_R_REL_DIRECT || result.mode == amd_pkg::AMD_R_REL_INDIRECT) |-> !result.use_y)
    else $error("relative jump took the second index");
  a_mem_short_only: assert property (state == S_OPCODE && take && op_mem_to_mem &&
    !(is_prefix && !have_prefix) |=> rmode != amd_pkg::AMD_R_DIR_LONG && rmode != amd_pkg::AMD_R_IDX_LONG &&
    rmode != amd_pkg::AMD_R_IND_LONG && rmode != amd_pkg::AMD_R_INDIDX_LONG)
    else $error("memory-to-memory opcode kept a long form");
  a_done_pulse: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_busy_prefix: assert property (state == S_OPCODE && take && is_prefix && !have_prefix |=>
    busy && ibyte_ready)
    else $error("held prefix not shown as busy");

  // Main scenarios that the bench is expected to reach.
  c_prefixed: cover property (done && result.use_y);
  c_relative: cover property (done && result.mode == amd_pkg::AMD_R_REL_INDIRECT);
  c_long_ind: cover property (done && result.mode == amd_pkg::AMD_R_INDIDX_LONG);
  c_mem_to_mem: cover property (state == S_OPCODE && take && op_mem_to_mem);
  c_idx_long: cover property (done && result.mode == amd_pkg::AMD_R_IDX_LONG);

endmodule
`default_nettype wire

// *** verif/amd_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model (
  input wire logic clk,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output var amd_pkg::amd_byte_t mem_rdata
);
  logic [7:0] mem [256];
  int cnt;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    mem_rdata = '0;
    cnt = 0;
  end

  // ----------------------------------------------------------------
  // Page-zero read port
  // ----------------------------------------------------------------
  // Outside a valid byte the data toggles every cycle, so a decoder that
  // samples a stale or early byte picks up garbage rather than a lucky match.
  always @(posedge clk) begin
    #1;
    if (mem_rdata.valid || !mem_req) begin
      mem_rdata.valid = 1'b0;
      mem_rdata.data = ~mem_rdata.data;
      cnt = 0;
    end else if (cnt >= int'(lat)) begin
      mem_rdata.valid = 1'b1;
      mem_rdata.data = mem[mem_addr[7:0]];
    end else begin
      cnt++;
      mem_rdata.data = ~mem_rdata.data;
    end
  end
endmodule
`default_nettype wire

// *** verif/amd_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); \
  end \
end
module amd_decoder_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  amd_pkg::amd_byte_t ibyte = '0;
  amd_pkg::amd_mode_t op_mode = amd_pkg::AMD_INHERENT;
  logic mm = 1'b0;
  logic [7:0] idx_x = 8'hFF;
  logic [7:0] idx_y = 8'h80;
  logic [3:0] lat = 4'h0;
  logic ibyte_ready, mem_req, done, busy;
  logic [15:0] mem_addr;
  amd_pkg::amd_byte_t mem_rdata;
  amd_pkg::amd_result_t result;
  int num_errors = 0;
  int tests_run = 0;
  logic [15:0] pc_exp = 16'h0000;

  amd_decoder u_dut (.clk(clk), .srst(srst), .ibyte(ibyte), .ibyte_ready(ibyte_ready), .op_mode(op_mode),
    .op_mem_to_mem(mm), .idx_x(idx_x), .idx_y(idx_y), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .done(done), .result(result), .busy(busy));
  amd_mem_model u_mem (.clk(clk), .lat(lat), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  always #25 clk = ~clk;

  function automatic logic [7:0] mv(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  task automatic put(input logic [7:0] b);
    ibyte = '{valid: 1'b1, data: b};
    do @(posedge clk); while (ibyte_ready !== 1'b1);
    #1;
  endtask

  // ----------------------------------------------------------------
  // One instruction: optional prefix, opcode, inline bytes, then done
  // ----------------------------------------------------------------
  task automatic run(input logic [7:0] pre, input amd_pkg::amd_mode_t m, input int nb,
      input logic [7:0] b1, input logic [7:0] b2, input amd_pkg::amd_rmode_t xm);
    logic [2:0] len;
    int k;
    len = 3'(1 + nb + int'(pre != 8'h00));
    op_mode = m;
    if (pre != 8'h00) begin
      put(pre);
      `CHK("busy", 1'b1, busy)
    end
    put(8'hA6);
    if (nb > 0) begin
      put(b1);
    end
    if (nb > 1) begin
      put(b2);
    end
    ibyte = '{valid: 1'b0, data: 8'hC3};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 40);
    `CHK("done", 1'b1, done)
    `CHK("length", len, result.length)
    `CHK("mode", xm, result.mode)
    `CHK("busy", 1'b0, busy)
    pc_exp = pc_exp + 16'(len);
    #1;
  endtask

  task automatic t_reset;
    `CHK("ready", 1'b1, ibyte_ready)
    `CHK("mem_req", 1'b0, mem_req)
    `CHK("busy", 1'b0, busy)
    `CHK("done", 1'b0, done)
    `CHK("result", 48'h0, result)
  endtask

  task automatic t_plain;
    run(8'h00, amd_pkg::AMD_INHERENT, 0, 8'h00, 8'h00, amd_pkg::AMD_R_INHERENT);
    `CHK("inherent length", 3'h1, result.length)
    run(8'h00, amd_pkg::AMD_IMMEDIATE, 1, 8'hC7, 8'h00, amd_pkg::AMD_R_IMMEDIATE);
    `CHK("operand", 8'hC7, result.operand)
    `CHK("use_y", 1'b0, result.use_y)
    run(8'h90, amd_pkg::AMD_IMMEDIATE, 1, 8'h3C, 8'h00, amd_pkg::AMD_R_IMMEDIATE);
    `CHK("use_y", 1'b1, result.use_y)
    `CHK("operand", 8'h3C, result.operand)
  endtask

  task automatic t_direct;
    run(8'h00, amd_pkg::AMD_DIRECT_SHORT, 1, 8'hF7, 8'h00, amd_pkg::AMD_R_DIR_SHORT);
    `CHK("ea", 16'h00F7, result.ea)
    run(8'h00, amd_pkg::AMD_DIRECT_LONG, 2, 8'h12, 8'h34, amd_pkg::AMD_R_DIR_LONG);
    `CHK("ea", 16'h1234, result.ea)
    mm = 1'b1;
    run(8'h00, amd_pkg::AMD_DIRECT_LONG, 1, 8'h9B, 8'h00, amd_pkg::AMD_R_DIR_SHORT);
    `CHK("ea", 16'h009B, result.ea)
    run(8'h00, amd_pkg::AMD_INDEXED_LONG, 1, 8'h10, 8'h00, amd_pkg::AMD_R_IDX_SHORT);
    `CHK("ea", 16'h010F, result.ea)
    mm = 1'b0;
  endtask

  task automatic t_indexed;
    run(8'h00, amd_pkg::AMD_INDEXED_NONE, 0, 8'h00, 8'h00, amd_pkg::AMD_R_IDX_NONE);
    `CHK("ea", 16'h00FF, result.ea)
    run(8'h00, amd_pkg::AMD_INDEXED_SHORT, 1, 8'hFF, 8'h00, amd_pkg::AMD_R_IDX_SHORT);
    `CHK("ea", 16'h01FE, result.ea)
    run(8'h00, amd_pkg::AMD_INDEXED_LONG, 2, 8'h12, 8'h34, amd_pkg::AMD_R_IDX_LONG);
    `CHK("ea", 16'h1333, result.ea)
    run(8'h90, amd_pkg::AMD_INDEXED_SHORT, 1, 8'hFF, 8'h00, amd_pkg::AMD_R_IDX_SHORT);
    `CHK("ea", 16'h017F, result.ea)
    `CHK("use_y", 1'b1, result.use_y)
    run(8'h00, amd_pkg::AMD_INDEXED_NONE, 0, 8'h00, 8'h00, amd_pkg::AMD_R_IDX_NONE);
    `CHK("ea", 16'h00FF, result.ea)
    `CHK("use_y", 1'b0, result.use_y)
  endtask

  task automatic t_indirect;
    lat = 4'h3;
    run(8'h92, amd_pkg::AMD_DIRECT_SHORT, 1, 8'hF0, 8'h00, amd_pkg::AMD_R_IND_SHORT);
    `CHK("ea", {8'h00, mv(8'hF0)}, result.ea)
    run(8'h92, amd_pkg::AMD_DIRECT_LONG, 1, 8'hF0, 8'h00, amd_pkg::AMD_R_IND_LONG);
    `CHK("ea", {mv(8'hF0), mv(8'hF1)}, result.ea)
    lat = 4'h0;
    run(8'h92, amd_pkg::AMD_INDEXED_SHORT, 1, 8'hF0, 8'h00, amd_pkg::AMD_R_INDIDX_SHORT);
    `CHK("ea", 16'h00FF + 16'(mv(8'hF0)), result.ea)
    run(8'h92, amd_pkg::AMD_INDEXED_LONG, 1, 8'hF0, 8'h00, amd_pkg::AMD_R_INDIDX_LONG);
    `CHK("ea", {mv(8'hF0), mv(8'hF1)} + 16'h00FF, result.ea)
    run(8'h91, amd_pkg::AMD_INDEXED_SHORT, 1, 8'hF0, 8'h00, amd_pkg::AMD_R_INDIDX_SHORT);
    `CHK("ea", 16'h0080 + 16'(mv(8'hF0)), result.ea)
    `CHK("use_y", 1'b1, result.use_y)
  endtask

  task automatic t_relative;
    run(8'h00, amd_pkg::AMD_RELATIVE, 1, 8'hFE, 8'h00, amd_pkg::AMD_R_REL_DIRECT);
    pc_exp = pc_exp - 16'h0002;
    `CHK("pc", pc_exp, result.pc)
    run(8'h00, amd_pkg::AMD_RELATIVE, 1, 8'h7F, 8'h00, amd_pkg::AMD_R_REL_DIRECT);
    pc_exp = pc_exp + 16'h007F;
    `CHK("pc", pc_exp, result.pc)
    lat = 4'h2;
    run(8'h92, amd_pkg::AMD_RELATIVE, 1, 8'hF2, 8'h00, amd_pkg::AMD_R_REL_INDIRECT);
    pc_exp = pc_exp + 16'($signed(mv(8'hF2)));
    `CHK("pc", pc_exp, result.pc)
    lat = 4'h0;
  endtask

  // A reset that lands between a prefix and its opcode must drop the prefix.
  task automatic t_mid_reset;
    put(8'h90);
    ibyte = '{valid: 1'b0, data: 8'hC3};
    srst = 1'b1;
    @(posedge clk);
    #1;
    srst = 1'b0;
    pc_exp = amd_pkg::PC_RESET;
    `CHK("busy", 1'b0, busy)
    `CHK("done", 1'b0, done)
    run(8'h00, amd_pkg::AMD_INDEXED_NONE, 0, 8'h00, 8'h00, amd_pkg::AMD_R_IDX_NONE);
    `CHK("use_y", 1'b0, result.use_y)
    `CHK("pc", pc_exp, result.pc)
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_plain();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_mid_reset();
    summarize();
  end

  // Roughly twenty instructions of under twenty cycles each; the margin is generous.
  initial begin
    #(3000 * 50);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
